// ===== hw/ref_path_pkg.sv
// Constants and carrier types for the reference-path configuration bank.
// Assumes an AXI4-Lite master with 32-bit data; registers take one word each.
// Function
// - Doubler enable bit switches doubler in
// - Multiplier code selects factor, 1 bypasses
// - Post-divider is bits 11..4 of 0x0B
// - Pre-divider is bits 11..0 of 0x0C
// - Pump gain 625 uA steps, zero tri-states
// - Software reset restores all seven registers to reset values
package ref_path_pkg;

  // Printed offsets are register indices; byte address is four times these
  localparam logic [7:0] IDX_DOUBLER = 8'h09;
  localparam logic [7:0] IDX_REFERENCE_MULTIPLIER_FACTOR = 8'h0A;
  localparam logic [7:0] IDX_POST_DIV = 8'h0B;
  localparam logic [7:0] IDX_PRE_DIV = 8'h0C;
  localparam logic [7:0] IDX_FIXED_A = 8'h0D;
  localparam logic [7:0] IDX_CP_GAIN = 8'h0E;
  localparam logic [7:0] IDX_FIXED_B = 8'h0F;
  localparam logic [7:0] IDX_SOFT_RESET = 8'h00;

  localparam int unsigned SOFT_RESET_BIT = 1;
  localparam int unsigned DOUBLER_BIT = 12;
  localparam int unsigned MULTIPLIER_HIGH_RANGE_FLAG_BIT = 14;
  localparam int unsigned REFERENCE_MULTIPLIER_FACTOR_LSB = 7;
  localparam int unsigned POST_DIV_LSB = 4;
  localparam int unsigned PRE_DIV_LSB = 0;
  localparam int unsigned CP_GAIN_LSB = 3;

  localparam logic [15:0] RST_DOUBLER = 16'h0004;
  localparam logic [15:0] RST_REFERENCE_MULTIPLIER_FACTOR = 16'h10F8;
  localparam logic [15:0] RST_POST_DIV = 16'hB018;
  localparam logic [15:0] RST_PRE_DIV = 16'h5001;
  localparam logic [15:0] RST_FIXED_A = 16'h4000;
  localparam logic [15:0] RST_CP_GAIN = 16'h1840;
  localparam logic [15:0] RST_FIXED_B = 16'h060E;

  localparam logic [4:0] REFERENCE_MULTIPLIER_FACTOR_BYPASS = 5'h01;
  localparam logic [4:0] REFERENCE_MULTIPLIER_FACTOR_MIN = 5'h03;
  localparam logic [4:0] REFERENCE_MULTIPLIER_FACTOR_MAX = 5'h07;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Settings delivered to the analog reference path
  typedef struct packed {
    logic doubler_en;
    logic reference_multiplier_factor_high_range;
    logic reference_multiplier_factor_bypass;
    logic [4:0] reference_multiplier_factor_factor;
    logic [7:0] post_div;
    logic [11:0] pre_div;
    logic [3:0] cp_gain;
    logic cp_tristate;
  } ref_path_cfg_t;

  typedef struct packed {
    logic [15:0] doubler;
    logic [15:0] reference_multiplier_factor;
    logic [15:0] post_div;
    logic [15:0] pre_div;
    logic [15:0] fixed_a;
    logic [15:0] cp_gain;
    logic [15:0] fixed_b;
  } reg_file_t;

endpackage

// ===== hw/reference_path_config_regs.sv
// AXI4-Lite register bank driving the reference path and charge pump settings.
// Assumes a single-clock system with one outstanding write and one read.
`timescale 1ns/10ps
`default_nettype none
module reference_path_config_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output var ref_path_pkg::ref_path_cfg_t cfg
);

  // Index decode reads address bits 9..2; narrower buses cannot reach the bank
  if (ADDR_W < 6 || ADDR_W > 16) begin : g_bad_addr_w
    $error("ADDR_W must be 6 to 16");
  end

  typedef struct packed {
    ref_path_pkg::reg_file_t regs;
    ref_path_pkg::ref_path_cfg_t cfg;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // Readies live in flops so no gate sits between a register and the bus
    logic awready;
    logic wready;
    logic arready;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic ref_path_pkg::reg_file_t reset_regs();
    ref_path_pkg::reg_file_t r;
    r.doubler = ref_path_pkg::RST_DOUBLER;
    r.reference_multiplier_factor = ref_path_pkg::RST_REFERENCE_MULTIPLIER_FACTOR;
    r.post_div = ref_path_pkg::RST_POST_DIV;
    r.pre_div = ref_path_pkg::RST_PRE_DIV;
    r.fixed_a = ref_path_pkg::RST_FIXED_A;
    r.cp_gain = ref_path_pkg::RST_CP_GAIN;
    r.fixed_b = ref_path_pkg::RST_FIXED_B;
    return r;
  endfunction

  // Word index of a byte address; only aligned words are mapped
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
    logic [15:0] wide;
    wide = 16'(a);
    return wide[9:2];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    logic [15:0] wide;
    i = word_index(a);
    wide = 16'(a);
    // Unaligned or aliased addresses are refused rather than folded onto a register
    return (wide[1:0] == 2'h0) && (wide[15:10] == 6'h00)
      && ((i == ref_path_pkg::IDX_SOFT_RESET)
      || (i >= ref_path_pkg::IDX_DOUBLER && i <= ref_path_pkg::IDX_FIXED_B));
  endfunction

  // Byte-lane merge of the low 16 bits
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] st);
    logic [15:0] m;
    m[7:0] = st[0] ? d[7:0] : old[7:0];
    m[15:8] = st[1] ? d[15:8] : old[15:8];
    return m;
  endfunction

  function automatic ref_path_pkg::ref_path_cfg_t decode(input ref_path_pkg::reg_file_t r);
    ref_path_pkg::ref_path_cfg_t c;
    c.doubler_en = r.doubler[ref_path_pkg::DOUBLER_BIT];
    c.reference_multiplier_factor_high_range = r.doubler[ref_path_pkg::MULTIPLIER_HIGH_RANGE_FLAG_BIT];
    c.reference_multiplier_factor_factor = r.reference_multiplier_factor[ref_path_pkg::REFERENCE_MULTIPLIER_FACTOR_LSB +: 5];
    // Unused and discouraged codes also bypass, so a bad setting never multiplies oddly
    c.reference_multiplier_factor_bypass = (c.reference_multiplier_factor_factor < ref_path_pkg::REFERENCE_MULTIPLIER_FACTOR_MIN)
      || (c.reference_multiplier_factor_factor > ref_path_pkg::REFERENCE_MULTIPLIER_FACTOR_MAX);
    c.post_div = r.post_div[ref_path_pkg::POST_DIV_LSB +: 8];
    c.pre_div = r.pre_div[ref_path_pkg::PRE_DIV_LSB +: 12];
    c.cp_gain = r.cp_gain[ref_path_pkg::CP_GAIN_LSB +: 4];
    c.cp_tristate = (c.cp_gain == 4'h0);
    return c;
  endfunction

  always_comb begin
    logic do_write;
    logic [7:0] idx;
    logic [15:0] nv;
    do_write = 1'b0;
    idx = 8'h00;
    nv = 16'h0000;
    s_d = s_q;
    if (s_axi_awvalid && !s_q.aw_held) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_held) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // Both halves are held and no response pending: commit the write
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      do_write = mapped(s_q.aw_addr);
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = mapped(s_q.aw_addr) ? ref_path_pkg::RESP_OKAY : ref_path_pkg::RESP_SLVERR;
      idx = word_index(s_q.aw_addr);
    end
    if (do_write) begin
      unique case (idx)
        ref_path_pkg::IDX_DOUBLER: begin
          s_d.regs.doubler = merge(s_q.regs.doubler, s_q.w_data, s_q.w_strb);
        end
        ref_path_pkg::IDX_REFERENCE_MULTIPLIER_FACTOR: begin
          s_d.regs.reference_multiplier_factor = merge(s_q.regs.reference_multiplier_factor, s_q.w_data, s_q.w_strb);
        end
        ref_path_pkg::IDX_POST_DIV: begin
          s_d.regs.post_div = merge(s_q.regs.post_div, s_q.w_data, s_q.w_strb);
        end
        ref_path_pkg::IDX_PRE_DIV: begin
          s_d.regs.pre_div = merge(s_q.regs.pre_div, s_q.w_data, s_q.w_strb);
        end
        ref_path_pkg::IDX_FIXED_A: begin
          s_d.regs.fixed_a = merge(s_q.regs.fixed_a, s_q.w_data, s_q.w_strb);
        end
        ref_path_pkg::IDX_CP_GAIN: begin
          s_d.regs.cp_gain = merge(s_q.regs.cp_gain, s_q.w_data, s_q.w_strb);
        end
        ref_path_pkg::IDX_FIXED_B: begin
          s_d.regs.fixed_b = merge(s_q.regs.fixed_b, s_q.w_data, s_q.w_strb);
        end
        ref_path_pkg::IDX_SOFT_RESET: begin
          nv = merge(16'h0000, s_q.w_data, s_q.w_strb);
          if (nv[ref_path_pkg::SOFT_RESET_BIT]) begin
            s_d.regs = reset_regs();
          end
        end
        default: begin
        end
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // A read is taken only while no read data is waiting
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = mapped(s_axi_araddr) ? ref_path_pkg::RESP_OKAY : ref_path_pkg::RESP_SLVERR;
      unique case (word_index(s_axi_araddr))
        ref_path_pkg::IDX_DOUBLER: s_d.rdata = {16'h0000, s_q.regs.doubler};
        ref_path_pkg::IDX_REFERENCE_MULTIPLIER_FACTOR: s_d.rdata = {16'h0000, s_q.regs.reference_multiplier_factor};
        ref_path_pkg::IDX_POST_DIV: s_d.rdata = {16'h0000, s_q.regs.post_div};
        ref_path_pkg::IDX_PRE_DIV: s_d.rdata = {16'h0000, s_q.regs.pre_div};
        ref_path_pkg::IDX_FIXED_A: s_d.rdata = {16'h0000, s_q.regs.fixed_a};
        ref_path_pkg::IDX_CP_GAIN: s_d.rdata = {16'h0000, s_q.regs.cp_gain};
        ref_path_pkg::IDX_FIXED_B: s_d.rdata = {16'h0000, s_q.regs.fixed_b};
        default: s_d.rdata = 32'h0000_0000;
      endcase
      if (!mapped(s_axi_araddr)) begin
        s_d.rdata = 32'h0000_0000;
      end
    end
    s_d.awready = !s_d.aw_held;
    s_d.wready = !s_d.w_held;
    s_d.arready = !s_d.rvalid;
    s_d.cfg = decode(s_d.regs);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.regs <= reset_regs();
      s_q.cfg <= decode(reset_regs());
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Ready is registered: each channel accepts one item while its holding slot is empty
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign cfg = s_q.cfg;

endmodule
`default_nettype wire

// ===== sim/ref_path_props.sv
// Checker for the reference-path register bank, bound to its ports.
// Assumes ADDR_W of 8, so byte addresses compare as 8-bit values.
`timescale 1ns/10ps
`default_nettype none
module ref_path_props #(parameter int ADDR_W = 8) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire ref_path_pkg::ref_path_cfg_t cfg
);
  logic [ADDR_W-1:0] ad_q;
  logic [15:0] wd_q;
  // Remember the write in flight so it can be judged when it commits
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) ad_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[15:0];
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_doubler_follows: assert property ($rose(s_axi_bvalid) && ad_q == 8'h24 |->
    cfg.doubler_en == wd_q[12] && cfg.reference_multiplier_factor_high_range == wd_q[14])
    else $error("doubler settings wrong");
  a_reference_multiplier_factor_decode: assert property ($rose(s_axi_bvalid) && ad_q == 8'h28 |->
    cfg.reference_multiplier_factor_factor == wd_q[11:7] && cfg.reference_multiplier_factor_bypass == !(wd_q[11:7] inside {[3:7]}))
    else $error("multiplier decode wrong");
  a_post_div: assert property ($rose(s_axi_bvalid) && ad_q == 8'h2C |->
    cfg.post_div == wd_q[11:4]) else $error("post divider wrong");
  a_pre_div: assert property ($rose(s_axi_bvalid) && ad_q == 8'h30 |->
    cfg.pre_div == wd_q[11:0]) else $error("pre divider wrong");
  a_pump_gain: assert property ($rose(s_axi_bvalid) && ad_q == 8'h38 |->
    cfg.cp_gain == wd_q[6:3] && cfg.cp_tristate == (wd_q[6:3] == 4'h0))
    else $error("pump gain wrong");
  a_soft_restore: assert property ($rose(s_axi_bvalid) && ad_q == 8'h00 && wd_q[1] |->
    cfg.pre_div == 12'h001 && cfg.post_div == 8'h01 && cfg.cp_gain == 4'h8)
    else $error("soft reset left settings");
  a_cfg_holds: assert property ($past(aresetn) && !$rose(s_axi_bvalid) |->
    $stable(cfg)) else $error("settings moved without a write");
  a_write_commit: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write not answered");
endmodule
bind reference_path_config_regs ref_path_props #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

// ===== sim/host_model.sv
// Host controller: AXI4-Lite master that programs the bank with legal words.
// Assumes the bench calls its tasks just after a rising edge of aclk.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  output logic s_axi_rready
);
  // Response readies stay high, so no answer is ever stalled here
  initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr} = '0;
  initial {s_axi_arvalid, s_axi_bready, s_axi_rready} = 3'h3;
  task automatic wr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, v};
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  function automatic logic [15:0] w9(input logic dbl, input logic hi);
    return {1'b0, hi, 1'b0, dbl, 12'h004};
  endfunction
  function automatic logic [15:0] w10(input logic [4:0] f);
    return {4'h1, f, 7'h78};
  endfunction
  function automatic logic [15:0] w11(input logic [7:0] d);
    return {4'hB, d, 4'h8};
  endfunction
  function automatic logic [15:0] w12(input logic [11:0] d);
    return {4'h5, d};
  endfunction
  function automatic logic [15:0] w14(input logic [3:0] g);
    return {9'h030, g, 3'h0};
  endfunction
  function automatic logic [15:0] wfix(input logic b);
    return b ? 16'h060E : 16'h4000;
  endfunction
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the reference-path register bank.
// Assumes the host model drives the bus and a shadow copy predicts all.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  ref_path_pkg::ref_path_cfg_t cfg;
  logic [15:0] sh [9:15];
  int failures = 0, checked = 0;
  always #5 aclk = ~aclk;
  reference_path_config_regs DUT (.*);
  host_model host (.*);
  task automatic wrap_up();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      failures++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  function automatic ref_path_pkg::ref_path_cfg_t ex();
    ref_path_pkg::ref_path_cfg_t c;
    c = {sh[9][12], sh[9][14], 1'b0, sh[10][11:7], sh[11][11:4], sh[12][11:0], sh[14][6:3], 1'b0};
    c.reference_multiplier_factor_bypass = !(c.reference_multiplier_factor_factor inside {[3:7]});
    c.cp_tristate = c.cp_gain == 4'h0;
    return c;
  endfunction
  task automatic rv();
    sh = '{16'h0004, 16'h10F8, 16'hB018, 16'h5001, 16'h4000, 16'h1840, 16'h060E};
  endtask
  task automatic put(input int i, input logic [15:0] v);
    logic [1:0] r;
    logic [31:0] d;
    host.wr(8'(i * 4), v, r);
    sh[i] = v;
    chk(r === 2'h0 && cfg === ex(), "decode");
    host.rd(8'(i * 4), d, r);
    chk(r === 2'h0 && d === {16'h0000, v}, "readback");
  endtask
  task automatic rall(input string s);
    logic [1:0] r;
    logic [31:0] d;
    for (int i = 9; i < 16; i++) begin
      host.rd(8'(i * 4), d, r);
      chk(d === {16'h0000, sh[i]} && cfg === ex(), "held value");
    end
    $display("test %s done", s);
  endtask
  task automatic hrst();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rv();
    @(posedge aclk);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    wrap_up();
  end
  initial begin
    int lo, hi, f;
    logic [1:0] r;
    logic [31:0] d;
    lo = $urandom(32'h8A9E);
    hrst();
    rall("reset values");
    put(11, host.w11(8'hFF));
    put(12, host.w12(12'hFFF));
    for (int i = 0; i < 8; i++) put(10, host.w10(5'(i)));
    for (int i = 0; i < 16; i++) put(14, host.w14(4'(i)));
    repeat (40) begin
      f = $urandom_range(7, 3);
      lo = (60 + f - 1) / f < 10 ? 10 : (60 + f - 1) / f;
      hi = 150 / f > 40 ? 40 : 150 / f;
      case ($urandom_range(3, 0))
        0: put(11, host.w11(8'($urandom())));
        1: put(12, host.w12(12'($urandom())));
        2: put(14, host.w14(4'($urandom())));
        default: begin
          put(10, host.w10(5'(f)));
          put(9, host.w9(1'($urandom()), $urandom_range(hi, lo) * f > 100));
        end
      endcase
    end
    put(13, host.wfix(1'b0));
    put(15, host.wfix(1'b1));
    host.wr(8'h40, 16'hFFFF, r);
    chk(r === 2'h2 && cfg === ex(), "unmapped write");
    host.rd(8'h40, d, r);
    chk(r === 2'h2 && d === 32'h0, "unmapped read");
    host.wr(8'h25, 16'hFFFF, r);
    chk(r === 2'h2 && cfg === ex(), "unaligned write");
    rall("random and unmapped");
    host.wr(8'h00, 16'h0002, r);
    rv();
    chk(r === 2'h0, "soft reset response");
    rall("soft reset");
    put(9, host.w9(1'b1, 1'b1));
    hrst();
    rall("hard reset");
    wrap_up();
  end
endmodule
`default_nettype wire
